// ### sbf_consts.svh
// Purpose: Offsets, field positions, reset values and counts for the block.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes: Included by the design only; the package does not include it.
`ifndef SBF_CONSTS_SVH
`define SBF_CONSTS_SVH

`define SBF_ADDR_W 3
`define SBF_OFF_CTRL1 3'h0
`define SBF_OFF_CTRL2 3'h1
`define SBF_OFF_BAUD 3'h2
`define SBF_OFF_STATUS 3'h3
`define SBF_OFF_DATA 3'h4

`define SBF_C1_RXIE 7
`define SBF_C1_ON 6
`define SBF_C1_TXIE 5
`define SBF_C1_MASTER_SELECT 4
`define SBF_C2_FAULTEN 4
`define SBF_C1_SELECT_OUTPUT_ENABLE 1

`define SBF_ST_RXFULL 7
`define SBF_ST_TXROOM 5
`define SBF_ST_CONFLICT 4

`define SBF_RST_CTRL1 8'h04
`define SBF_RST_CTRL2 8'h00
`define SBF_RST_BAUD 8'h00
`define SBF_BAUD_MASK 8'h77
`define SBF_C2_MASK 8'h1b

`define SBF_SHIFT_BITS 4'h8

`endif

// ### sbf_far_model.sv
// Purpose: Far-side serial device seen by the flag block.
// Assumes: One fixed reply byte per run.
// Notes: The reply byte is held one clock past a transfer; otherwise the byte shows its inverse.
`default_nettype none
module sbf_far_model #(
  parameter logic [7:0] replyByte = 8'h3c
) (
  input wire logic clk,
  input wire logic shifting,
  input wire logic contend,
  output logic slaveSelect_n,
  output logic slaveShiftDone,
  output logic [7:0] rxShiftByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held_q = 1'b0;
  always_ff @(posedge clk) held_q <= shifting;
  // Pulled up, so a quiet rival leaves the select high
  assign slaveSelect_n = !contend;
  assign slaveShiftDone = 1'b0;
  assign rxShiftByte = (shifting || held_q) ? replyByte : ~replyByte;
endmodule : sbf_far_model
`default_nettype wire

// ### sbf_pkg.sv
// Purpose: Types shared by the baud and status-flag logic.
// Assumes: State codes are literals here; nothing comes from the header.
// Notes: States are binary coded.
`default_nettype none
package sbf_pkg;
  typedef enum logic [1:0] {
    SBF_IDLE = 2'b00,
    SBF_LOAD = 2'b01,
    SBF_SHIFT = 2'b10
  } sbf_state_t;
endpackage : sbf_pkg
`default_nettype wire

// ### sbf_spi_flags.sv
// Purpose: Bit-rate generator and status flags of a serial peripheral port.
// Assumes: Inputs synchronous to clk; shifter lives outside this block.
// Notes: Shift length is modelled by counting bit-clock periods.
//   Slave-mode transfers end only on the external shifter's pulse.
//   Receive overrun drops the new byte with no indication.
//   Clearing arms drop as soon as their flag falls.
//
// Implementation choices: the register addresses and strobed register access.
`include "sbf_consts.svh"
`default_nettype none
module sbf_spi_flags
  import sbf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`SBF_ADDR_W-1:0] addr,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [7:0] readData,
  input wire logic slaveSelect_n,
  input wire logic slaveShiftDone,
  input wire logic [7:0] rxShiftByte,
  output logic bitClock,
  output logic bitTick,
  output logic [7:0] txShiftByte,
  output logic txLoad,
  output logic shifting,
  output logic txRoomIrq,
  output logic rxFaultIrq
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rstN;
  sbf_reset_sync u_sbf_reset_sync (
    .clk(clk),
    .reset_n(reset_n),
    .rstN(rstN)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] baud_q;
  logic [7:0] txBuf_q;
  logic [7:0] rxBuf_q;
  logic rxFull_q;
  logic txRoom_q;
  logic conflict_q;
  logic rxArmed_q;
  logic txArmed_q;
  logic faultArmed_q;
  logic txPending_q;

  wire selCtrl1 = addr == `SBF_OFF_CTRL1;
  wire selCtrl2 = addr == `SBF_OFF_CTRL2;
  wire selBaud = addr == `SBF_OFF_BAUD;
  wire selStatus = addr == `SBF_OFF_STATUS;
  wire selData = addr == `SBF_OFF_DATA;
  wire wrCtrl1 = writeStrobe && selCtrl1;
  wire wrCtrl2 = writeStrobe && selCtrl2;
  wire wrBaud = writeStrobe && selBaud;
  wire wrData = writeStrobe && selData;
  wire rdStatus = readStrobe && selStatus;
  wire rdData = readStrobe && selData;

  wire moduleOn = ctrl1_q[`SBF_C1_ON];
  wire masterSelect = ctrl1_q[`SBF_C1_MASTER_SELECT];
  wire faultFunctionEnable = ctrl2_q[`SBF_C2_FAULTEN];
  wire selectOutputEnable = ctrl1_q[`SBF_C1_SELECT_OUTPUT_ENABLE];
  wire [2:0] prescaleSelect = baud_q[6:4];
  wire [2:0] rateDividerSelect = baud_q[2:0];

  // no write path exists for the status word
  wire [7:0] statusWord = {rxFull_q, 1'b0, txRoom_q, conflict_q, 4'h0};

  wire [7:0] readMux =
    selCtrl1 ? ctrl1_q :
    selCtrl2 ? ctrl2_q :
    selBaud ? baud_q :
    selStatus ? statusWord :
    selData ? rxBuf_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Baud generation
  logic [2:0] preCount_q;
  logic [7:0] divCount_q;
  logic bitClock_q;
  logic bitTick_q;

  // Counters held at zero outside a transfer, so bit one is full length
  wire runClock = moduleOn && masterSelect && shifting;
  wire preWrap = preCount_q == prescaleSelect;
  // Half period of divider in prescaler ticks: 2^code
  wire [7:0] halfLimit = 8'h01 << rateDividerSelect;
  wire divWrap = preWrap && (divCount_q == halfLimit - 8'h01);
  wire [2:0] preCountD = (!runClock || preWrap) ? 3'h0
                                                : preCount_q + 3'h1;
  wire [7:0] divCountD = !runClock ? 8'h00 :
                         divWrap ? 8'h00 :
                         preWrap ? divCount_q + 8'h01 : divCount_q;
  // A full bit period ends on the falling half of the bit clock
  wire bitEnd = divWrap && bitClock_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      preCount_q <= 3'h0;
      divCount_q <= 8'h00;
      bitClock_q <= 1'b0;
      bitTick_q <= 1'b0;
    end else begin
      preCount_q <= preCountD;
      divCount_q <= divCountD;
      bitClock_q <= runClock ? (bitClock_q ^ divWrap) : 1'b0;
      bitTick_q <= runClock && bitEnd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  sbf_state_t state_q;
  sbf_state_t stateD;
  logic [3:0] bitCount_q;

  // Slave transfers have no bit clock here and end on the shifter pulse
  wire masterDone = masterSelect && (state_q == SBF_SHIFT) && bitEnd &&
                    (bitCount_q == `SBF_SHIFT_BITS - 4'h1);
  wire slaveDone = !masterSelect && (state_q == SBF_SHIFT) &&
                   slaveShiftDone;
  wire shiftDone = moduleOn && (masterDone || slaveDone);
  wire acceptWrite = wrData && txArmed_q && txRoom_q;
  wire moveToShifter = moduleOn && (state_q == SBF_LOAD);

  always_comb begin
    stateD = state_q;
    case (state_q)
      SBF_IDLE: begin
        if (txPending_q) begin
          stateD = SBF_LOAD;
        end
      end
      SBF_LOAD: begin
        stateD = SBF_SHIFT;
      end
      SBF_SHIFT: begin
        if (shiftDone) begin
          stateD = txPending_q ? SBF_LOAD : SBF_IDLE;
        end
      end
      default: begin
        stateD = SBF_IDLE;
      end
    endcase
    if (!moduleOn) begin
      stateD = SBF_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= SBF_IDLE;
      bitCount_q <= 4'h0;
    end else begin
      state_q <= stateD;
      // Counts whole bit periods, ended on the falling half
      if (state_q != SBF_SHIFT) begin
        bitCount_q <= 4'h0;
      end else if (bitEnd) begin
        bitCount_q <= bitCount_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags
  wire faultInput = masterSelect && faultFunctionEnable &&
                    !selectOutputEnable;
  wire faultEvent = moduleOn && faultInput && !slaveSelect_n;
  wire rxClear = rdData && rxArmed_q;
  wire faultClear = wrCtrl1 && faultArmed_q;

  // Set terms sit first so an event wins over a clear
  wire rxFullD = !moduleOn ? 1'b0 :
                 shiftDone ? 1'b1 :
                 rxClear ? 1'b0 : rxFull_q;
  wire txRoomD = !moduleOn ? 1'b1 :
                 moveToShifter ? 1'b1 :
                 acceptWrite ? 1'b0 : txRoom_q;
  wire conflictD = faultEvent ? 1'b1 :
                   faultClear ? 1'b0 : conflict_q;
  // A write landing beside a move keeps the new byte queued
  wire txPendingD = !moduleOn ? 1'b0 :
                    acceptWrite ? 1'b1 :
                    moveToShifter ? 1'b0 : txPending_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxFull_q <= 1'b0;
      txRoom_q <= 1'b1;
      conflict_q <= 1'b0;
      txPending_q <= 1'b0;
    end else begin
      rxFull_q <= rxFullD;
      txRoom_q <= txRoomD;
      conflict_q <= conflictD;
      txPending_q <= txPendingD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clearing sequences: a status read that saw the flag set
  // Receive: status read then data read
  sbf_arm_bit u_rx_arm (
    .clk(clk),
    .rstN(rstN),
    .statusRead(rdStatus),
    .flagNow(rxFull_q),
    .accessDone(rdData),
    .armed(rxArmed_q)
  );

  // Room: status read then data write
  sbf_arm_bit u_tx_arm (
    .clk(clk),
    .rstN(rstN),
    .statusRead(rdStatus),
    .flagNow(txRoom_q),
    .accessDone(wrData),
    .armed(txArmed_q)
  );

  // Conflict: status read then control 1 write
  sbf_arm_bit u_fault_arm (
    .clk(clk),
    .rstN(rstN),
    .statusRead(rdStatus),
    .flagNow(conflict_q),
    .accessDone(wrCtrl1),
    .armed(faultArmed_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers and data buffers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl1_q <= `SBF_RST_CTRL1;
      ctrl2_q <= `SBF_RST_CTRL2;
      baud_q <= `SBF_RST_BAUD;
      txBuf_q <= 8'h00;
      rxBuf_q <= 8'h00;
      readData <= 8'h00;
    end else begin
      if (wrCtrl1) begin
        ctrl1_q <= writeData;
      end
      if (wrCtrl2) begin
        ctrl2_q <= writeData & `SBF_C2_MASK;
      end
      if (wrBaud) begin
        baud_q <= writeData & `SBF_BAUD_MASK;
      end
      if (acceptWrite) begin
        txBuf_q <= writeData;
      end
      // Overrun: new byte lost while the buffer is still full
      if (shiftDone && !rxFull_q) begin
        rxBuf_q <= rxShiftByte;
      end
      // Zero outside its one cycle, so no stale byte lingers on the bus
      readData <= readStrobe ? readMux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bitClock <= 1'b0;
      bitTick <= 1'b0;
      txShiftByte <= 8'h00;
      txLoad <= 1'b0;
      shifting <= 1'b0;
      txRoomIrq <= 1'b0;
      rxFaultIrq <= 1'b0;
    end else begin
      bitClock <= bitClock_q;
      bitTick <= bitTick_q;
      txLoad <= moveToShifter;
      if (moveToShifter) begin
        txShiftByte <= txBuf_q;
      end
      shifting <= (stateD == SBF_SHIFT);
      txRoomIrq <= txRoomD && ctrl1_q[`SBF_C1_TXIE];
      rxFaultIrq <= (rxFullD || conflictD) &&
                    ctrl1_q[`SBF_C1_RXIE];
    end
  end

endmodule : sbf_spi_flags

////////////////////////////////////////////////////////////////////////
// Reset release: asserts at once, lets go two edges later
module sbf_reset_sync
  import sbf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  output logic rstN
);
  // Only the second stage is read, so a late release never splits
  logic rstMeta_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN <= rstMeta_q;
    end
  end
endmodule : sbf_reset_sync

////////////////////////////////////////////////////////////////////////
// One arming bit of a read-then-access clearing sequence
module sbf_arm_bit
  import sbf_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic statusRead,
  input wire logic flagNow,
  input wire logic accessDone,
  output logic armed
);
  // A status read re-arms from the flag as it stands
  // The access itself or a falling flag drops the arm
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      armed <= 1'b0;
    end else if (statusRead) begin
      armed <= flagNow;
    end else if (accessDone || !flagNow) begin
      armed <= 1'b0;
    end
  end
endmodule : sbf_arm_bit
`default_nettype wire

// ### sbf_spi_flags_sva.sv
// Purpose: Port-level checks of the baud and status-flag block.
// Assumes: Control 1 at offset 0, status at offset 3.
// Notes: Interrupt enables are shadowed from bus writes.
`default_nettype none
module sbf_spi_flags_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [7:0] readData,
  input wire logic bitClock,
  input wire logic bitTick,
  input wire logic txLoad,
  input wire logic shifting,
  input wire logic txRoomIrq,
  input wire logic rxFaultIrq
);
  logic [7:0] ctrl1_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ctrl1_q <= 8'h04;
    else if (writeStrobe && addr == 3'h0) ctrl1_q <= writeData;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  idle_read_zero_a: assert property (
    !$past(readStrobe) |-> readData == 8'h00)
    else $error("read data not zero");
  status_pad_zero_a: assert property (
    $past(readStrobe) && $past(addr) == 3'h3 |->
    readData[6] == 1'b0 && readData[3:0] == 4'h0)
    else $error("unused status bit set");
  tx_irq_off_a: assert property (
    !ctrl1_q[5] && !$past(ctrl1_q[5]) |-> !txRoomIrq)
    else $error("room irq while disabled");
  tx_irq_on_a: assert property (
    $past(readStrobe) && $past(addr) == 3'h3 && readData[5] &&
    ctrl1_q[5] && $past(ctrl1_q[5]) |-> txRoomIrq)
    else $error("room irq missing");
  rx_irq_off_a: assert property (
    !ctrl1_q[7] && !$past(ctrl1_q[7]) |-> !rxFaultIrq)
    else $error("rx irq while disabled");
  off_idle_a: assert property (
    !ctrl1_q[6] && !$past(ctrl1_q[6]) |-> !shifting)
    else $error("shifting while off");
  load_shift_a: assert property (
    txLoad |-> shifting)
    else $error("load without shifting");
  tick_pulse_a: assert property (
    bitTick |=> !bitTick)
    else $error("bit tick too long");
  shift_len_a: assert property (
    $rose(shifting) |-> (shifting || !ctrl1_q[6]) [*8])
    else $error("transfer too short");
  clock_quiet_a: assert property (
    !shifting [*3] |-> $stable(bitClock))
    else $error("bit clock moved idle");
endmodule : sbf_spi_flags_sva
`default_nettype wire

// ### sbf_spi_flags_tb.sv
// Purpose: Directed bus-level test of the baud and status-flag block.
// Assumes: Offsets 0 ctrl1, 1 ctrl2, 2 baud, 3 status, 4 data.
// Notes: Fastest baud keeps the first two transfers at 16 clocks.
`default_nettype none
module sbf_spi_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] Reply = 8'h3c;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] writeData = 8'h00;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic contend = 1'b0;
  logic slaveSelect_n, slaveShiftDone, bitClock, bitTick, txLoad, shifting;
  logic txRoomIrq, rxFaultIrq;
  logic [7:0] readData, rxShiftByte, txShiftByte;
  int failCount = 0;
  int totalChecks = 0;
  int loads = 0;
  int n;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (txLoad === 1'b1) loads <= loads + 1;
  // Clocks between the last two bit ticks
  int tickGap = 0;
  int lastGap = 0;
  always @(posedge clk) begin
    if (bitTick === 1'b1) begin
      lastGap <= tickGap;
      tickGap <= 1;
    end else begin
      tickGap <= tickGap + 1;
    end
  end
  sbf_spi_flags u_sbf_spi_flags (.clk(clk), .reset_n(reset_n), .addr(addr),
    .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData),
    .slaveSelect_n(slaveSelect_n), .slaveShiftDone(slaveShiftDone),
    .rxShiftByte(rxShiftByte), .bitClock(bitClock), .bitTick(bitTick),
    .txShiftByte(txShiftByte), .txLoad(txLoad), .shifting(shifting),
    .txRoomIrq(txRoomIrq), .rxFaultIrq(rxFaultIrq));
  sbf_far_model #(.replyByte(Reply)) u_sbf_far_model (.clk(clk),
    .shifting(shifting), .contend(contend), .slaveSelect_n(slaveSelect_n),
    .slaveShiftDone(slaveShiftDone), .rxShiftByte(rxShiftByte));
  task automatic chk(input string name, input logic [7:0] exp,
      input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 chk("readData", exp, readData);
  endtask : rd
  task automatic endSim;
    if (failCount == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : endSim
  initial begin
    repeat (4000) @(posedge clk);
    failCount++;
    endSim();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(3'h0, 8'h50);
    wr(3'h4, 8'h11);
    repeat (3) @(posedge clk);
    #1 chk("loads", 8'h00, loads[7:0]);
    rd(3'h3, 8'h20);
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h77);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'hff);
    rd(3'h3, 8'h20);
    rd(3'h7, 8'h00);
    wr(3'h4, 8'ha5);
    repeat (2) @(posedge clk);
    #1 chk("shifting", 8'h01, {7'h00, shifting});
    rd(3'h3, 8'h20);
    wr(3'h4, 8'h5a);
    rd(3'h3, 8'h00);
    for (n = 0; n < 200 && loads < 2; n++) @(posedge clk);
    for (n = 0; n < 200 && shifting !== 1'b0; n++) @(posedge clk);
    #1 chk("loads", 8'h02, loads[7:0]);
    chk("txShiftByte", 8'h5a, txShiftByte);
    chk("bitGap", 8'h02, lastGap[7:0]);
    rd(3'h3, 8'ha0);
    rd(3'h4, Reply);
    rd(3'h3, 8'h20);
    wr(3'h2, 8'h11);
    wr(3'h4, 8'hc3);
    for (n = 0; n < 200 && loads < 3; n++) @(posedge clk);
    for (n = 0; n < 300 && shifting !== 1'b0; n++) @(posedge clk);
    #1 chk("txShiftByte", 8'hc3, txShiftByte);
    chk("bitGap", 8'h08, lastGap[7:0]);
    rd(3'h3, 8'ha0);
    rd(3'h4, Reply);
    wr(3'h0, 8'hf0);
    repeat (2) @(posedge clk);
    #1 chk("txRoomIrq", 8'h01, {7'h00, txRoomIrq});
    chk("rxFaultIrq", 8'h00, {7'h00, rxFaultIrq});
    wr(3'h1, 8'h10);
    wr(3'h0, 8'hd2);
    contend <= 1'b1;
    repeat (3) @(posedge clk);
    rd(3'h3, 8'h20);
    wr(3'h0, 8'hf0);
    repeat (2) @(posedge clk);
    rd(3'h3, 8'h30);
    chk("rxFaultIrq", 8'h01, {7'h00, rxFaultIrq});
    contend <= 1'b0;
    wr(3'h0, 8'hf0);
    rd(3'h3, 8'h20);
    wr(3'h4, 8'h77);
    repeat (3) @(posedge clk);
    wr(3'h0, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("shifting", 8'h00, {7'h00, shifting});
    rd(3'h3, 8'h20);
    endSim();
  end
endmodule : sbf_spi_flags_tb
bind sbf_spi_flags sbf_spi_flags_sva u_sbf_spi_flags_sva (.clk(clk),
  .reset_n(reset_n), .addr(addr), .writeData(writeData),
  .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
  .bitClock(bitClock), .bitTick(bitTick), .txLoad(txLoad),
  .shifting(shifting), .txRoomIrq(txRoomIrq), .rxFaultIrq(rxFaultIrq));
`default_nettype wire
